//--- rtl/cwo_config_loader.sv
// Configuration word loader with start-up timers, watchdog and sleep control
// Function
// [R1] Programmed bit reads zero, erased reads one
// [R2] Configuration held in one word at 2007h
// [R3] 2000h-3FFFh reachable only in programming mode
// [R4] Code protect field zero protects memory
// [R5] Bit 3 low enables power-up delay
// [R6] Bit 2 high enables watchdog
// [R7] Bits 1-0 select oscillator mode
// [R8] Watchdog off only by config, own clock
// [R9] Power-up delay 72 ms, power-on only
// [R10] Start-up timer holds reset until oscillator stable
// [R11] Sleep left on reset, watchdog, interrupt
// [R12] Crystal modes need crystal or external clock
// [R13] Word captured at power-on, then held stable
//
// Local design decision: the Wishbone interface to the registers.
`timescale 1ns/1ps
`default_nettype none
// Register map, byte offsets on the bus
//   00  configuration word, read only
//   04  programming mode, bit 0
//   08  programming address, bits 13:0
//   0c  programming data for the word
//   10  status flags
//   14  spare, reads zero
//   others read zero, writes dropped
// Status register layout
//   bit 7  watchdog time-out pulse
//   bit 6  sleeping
//   bit 5  core held in reset
//   bit 4  start-up sequence done
//   bit 3  code protected
//   bit 2  power-up delay enabled
//   bit 1  watchdog enabled
//   bit 0  reads zero
// Bus timing
//   Request taken while ack is low
//   Ack one cycle after the request
//   Write lands on the taking edge
//   Read data registered with the ack
//   Every access answered, mapped or not
// Programming flow
//   Set programming mode first
//   Load the word address next
//   Then write the data word
//   Leave programming mode afterwards
//   New settings apply after the next reset
//   Data access outside the mode reads zero
// Word storage
//   Behaves as non-volatile storage
//   Starts erased, all ones
//   Reset leaves the stored word alone
//   Only a programming write changes it
// Start-up flow after reset release
//   Capture word into settings, one cycle
//   Optional fixed power-up delay
//   Oscillator settle count in crystal modes
//   Resistor-capacitor mode skips the count
//   Then the core leaves reset
// Watchdog
//   Enabled only by the captured word
//   No software path turns it off
//   Counts its own oscillator ticks
//   Fire in run pulses the core reset
//   Fire in sleep wakes without reset
// Sleep
//   Entered on request once running
//   Left on external reset request
//   Left on watchdog fire or wake interrupt
// Hazards
//   Settings never follow the word while running
//   Delay timers rerun only after a full reset
//   External reset request does not rerun them
module cwo_config_loader #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYC = cwo_pkg::POWERUP_DELAY_TIMER_CYCLES,
  parameter int unsigned WDT_CYC  = cwo_pkg::WDT_PERIOD_CYC
) (
  // Clock and power-on reset
  input  wire logic         clk,
  input  wire logic         rst,
  // Wishbone classic slave
  input  wire logic         wb_cyc_i,
  input  wire logic         wb_stb_i,
  input  wire logic         wb_we_i,
  input  wire logic [7:0]   wb_adr_i,
  input  wire logic [3:0]   wb_sel_i,
  input  wire logic [31:0]  wb_dat_i,
  output logic      [31:0]  wb_dat_o,
  output logic              wb_ack_o,
  // Reset, sleep and oscillator events
  input  wire logic         ext_reset_req,
  input  wire logic         irq_wake,
  input  wire logic         sleep_req,
  input  wire logic         wdt_clear,
  input  wire logic         osc_tick,
  input  wire logic         wdt_rc_tick,
  // Applied settings
  output logic              core_reset,
  output logic              sleeping,
  output logic              wdt_timeout,
  output logic              code_protected,
  output logic              wdt_enabled,
  output logic [1:0]        osc_mode_select
);

  // Non-volatile word and captured settings
  logic [13:0]      device_configuration_word;
  cwo_pkg::cwo_cfg_s cfg;
  logic             prog_mode;
  logic [13:0]      prog_addr;
  // Low until the erased word is loaded once
  logic             cfg_valid = 1'b0;

  // Start-up sequence
  typedef enum logic [1:0] {CWO_CAPTURE, CWO_POWERUP_DELAY_TIMER, CWO_OST, CWO_RUN} cwo_state_e;
  cwo_state_e       state;
  logic [31:0]      powerup_delay_timer_cnt;
  logic [10:0]      ost_cnt;
  logic [31:0]      wdt_cnt;
  logic             wdt_fire;
  logic             ext_reset_seen;

  // Bus decode
  logic             bus_req;
  logic             bus_wr;
  logic             in_test_space;
  logic [13:0]      next_word;

  // A request is taken only while ack is low,
  // so each access is answered exactly once
  assign bus_req       = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr        = bus_req && wb_we_i;
  // Test space window only while in programming mode
  assign in_test_space = prog_mode && (prog_addr >= cwo_pkg::TEST_SPACE_LO)
                         && (prog_addr <= cwo_pkg::TEST_SPACE_HI); // [R3]
  // Programming writes the data word as given; erase via all-ones data
  assign next_word     = wb_dat_i[13:0];

  // Ack one cycle after request
  // Drops on the next edge since the request
  // is masked while ack stands
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Programming mode and address registers
  // Both cleared by reset, so the test space
  // closes again after every reset
  always_ff @(posedge clk) begin
    if (rst) begin
      prog_mode <= 1'b0;
      prog_addr <= 14'h0000;
    end else if (bus_wr && wb_sel_i[0]) begin
      if (wb_adr_i == cwo_pkg::REG_PROG_CTRL) begin
        prog_mode <= wb_dat_i[0];
      end
      if (wb_adr_i == cwo_pkg::REG_PROG_ADDR) begin
        prog_addr <= wb_dat_i[13:0];
      end
    end
  end

  // Non-volatile word: survives rst, written only by programmer
  // Loaded with the erased pattern on the first edge only
  // Write needs programming mode and the word address
  // Both low byte lanes must be enabled
  always_ff @(posedge clk) begin
    if (!cfg_valid) begin
      device_configuration_word <= cwo_pkg::CFG_ERASED; // [R1]
    end else if (bus_wr && (wb_adr_i == cwo_pkg::REG_PROG_DATA) && (&wb_sel_i[1:0])
                 && in_test_space && (prog_addr == cwo_pkg::CFG_WORD_ADDR)) begin // [R2] [R3]
      device_configuration_word <= next_word;
    end
  end

  // Marks the word as initialised once (models erased part)
  // Reset never touches it, so programmed values survive
  always_ff @(posedge clk) begin
    if (!cfg_valid) begin
      cfg_valid <= 1'b1;
    end
  end

  // Read mux; test space reads zero outside programming mode
  always_ff @(posedge clk) begin
    if (rst) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (bus_req && !wb_we_i) begin
      unique case (wb_adr_i)
        cwo_pkg::REG_CFG_WORD:  wb_dat_o <= {18'h00000, device_configuration_word}; // [R1]
        cwo_pkg::REG_PROG_CTRL: wb_dat_o <= {31'h0, prog_mode};
        cwo_pkg::REG_PROG_ADDR: wb_dat_o <= {18'h00000, prog_addr};
        cwo_pkg::REG_PROG_DATA: wb_dat_o <= (in_test_space && prog_addr == cwo_pkg::CFG_WORD_ADDR)
                                            ? {18'h00000, device_configuration_word}
                                            : 32'h0000_0000; // [R3]
        // Status flags, one per bit
        cwo_pkg::REG_STATUS:    wb_dat_o <= {24'h000000,
                                             wdt_timeout,          // bit 7
                                             sleeping,             // bit 6
                                             core_reset,           // bit 5
                                             state == CWO_RUN,     // bit 4
                                             cfg.code_protect,     // bit 3
                                             cfg.powerup_delay_en, // bit 2
                                             cfg.watchdog_en,      // bit 1
                                             1'b0};                // bit 0
        default:                wb_dat_o <= 32'h0000_0000;
      endcase
    end
  end

  // Capture the word during power-on reset only
  // Runs on every edge while reset holds the capture state,
  // and once more on the first edge after release
  // No capture afterwards, so settings stay fixed in run
  always_ff @(posedge clk) begin
    if (state == CWO_CAPTURE) begin
      cfg.code_protect     <= (device_configuration_word[cwo_pkg::CP_MSB:cwo_pkg::CP_LSB]
                               != cwo_pkg::CP_OFF_VALUE); // [R4] [R13]
      cfg.powerup_delay_en <= !device_configuration_word[cwo_pkg::POWERUP_DELAY_ENABLE_N_BIT]; // [R5]
      cfg.watchdog_en      <= device_configuration_word[cwo_pkg::WATCHDOG_ENABLE_BIT_BIT]; // [R6] [R8]
      cfg.osc_mode         <= cwo_pkg::cwo_osc_e'(device_configuration_word[cwo_pkg::FOSC_MSB:
                                                  cwo_pkg::FOSC_LSB]); // [R7]
    end
  end

  // Power-on start-up sequence
  // Capture, power-up delay, oscillator settle, run
  // Delay skipped when its enable is off (word bit 3 set)
  // Settle count skipped in resistor-capacitor mode
  // Run holds until the next reset
  always_ff @(posedge clk) begin
    if (rst) begin
      state    <= CWO_CAPTURE;
      powerup_delay_timer_cnt <= 32'h0000_0000;
      ost_cnt  <= 11'h000;
    end else begin
      unique case (state)
        CWO_CAPTURE: begin
          state    <= CWO_POWERUP_DELAY_TIMER;
          powerup_delay_timer_cnt <= 32'h0000_0000;
        end
        CWO_POWERUP_DELAY_TIMER: begin
          // Fixed delay only when enabled, only after power-on
          if (!cfg.powerup_delay_en || powerup_delay_timer_cnt >= POWERUP_DELAY_TIMER_CYC - 1) begin // [R9]
            state   <= CWO_OST;
            ost_cnt <= 11'h000;
          end else begin
            powerup_delay_timer_cnt <= powerup_delay_timer_cnt + 32'h1;
          end
        end
        CWO_OST: begin
          // Crystal modes wait for oscillator edges; RC skips
          if (cfg.osc_mode == cwo_pkg::CWO_RC
              || ost_cnt == 11'(cwo_pkg::OST_OSC_CYCLES)) begin // [R10] [R12]
            state <= CWO_RUN;
          end else if (osc_tick) begin
            ost_cnt <= ost_cnt + 11'h1;
          end
        end
        CWO_RUN: state <= CWO_RUN;
      endcase
    end
  end

  // Watchdog on its own RC tick; no software disable
  // Counter held at zero until the start-up sequence ends
  // Clear input restarts the count, never stops it
  // Fire restarts the count as well
  assign wdt_fire = cfg.watchdog_en && wdt_rc_tick && (wdt_cnt >= WDT_CYC - 1); // [R8]
  always_ff @(posedge clk) begin
    if (rst || state != CWO_RUN || wdt_clear || wdt_fire) begin
      wdt_cnt <= 32'h0000_0000;
    end else if (cfg.watchdog_en && wdt_rc_tick) begin // [R8]
      wdt_cnt <= wdt_cnt + 32'h1;
    end
  end

  // External reset latch for the core reset
  // One cycle of delay before the core reset follows
  // Timers are not rerun by this path
  always_ff @(posedge clk) begin
    if (rst) begin
      ext_reset_seen <= 1'b0;
    end else begin
      ext_reset_seen <= ext_reset_req;
    end
  end

  // Sleep entry and wake
  // Wake events win over a request in the same cycle
  // Entry allowed only once the core is running
  // Reset always leaves the core awake
  always_ff @(posedge clk) begin
    if (rst) begin
      sleeping <= 1'b0;
    end else if (ext_reset_req || wdt_fire || irq_wake) begin // [R11]
      sleeping <= 1'b0;
    end else if (sleep_req && state == CWO_RUN) begin
      sleeping <= 1'b1;
    end
  end

  // Core reset: start-up not done, external reset, or watchdog in run
  // A watchdog fire while sleeping only wakes the core, so the old
  // sleeping value gates the reset here
  always_ff @(posedge clk) begin
    if (rst) begin
      core_reset <= 1'b1;
    end else begin
      core_reset <= (state != CWO_RUN) || ext_reset_seen
                    || (wdt_fire && !sleeping); // [R9] [R10]
    end
  end

  // Watchdog time-out flag, one cycle per fire
  // Follows the fire one edge late, like all outputs
  always_ff @(posedge clk) begin
    if (rst) begin
      wdt_timeout <= 1'b0;
    end else begin
      wdt_timeout <= wdt_fire;
    end
  end

  // Applied settings, copied from the captured word
  // They change only across a reset, never while running
  always_ff @(posedge clk) begin
    if (rst) begin
      code_protected  <= 1'b0;
      wdt_enabled     <= 1'b0;
      osc_mode_select <= 2'b11;
    end else begin
      code_protected  <= cfg.code_protect; // [R4]
      wdt_enabled     <= cfg.watchdog_en; // [R6]
      osc_mode_select <= cfg.osc_mode; // [R7]
    end
  end

endmodule : cwo_config_loader
`default_nettype wire

//--- rtl/cwo_pkg.sv
// Package: constants and types for the configuration word loader
package cwo_pkg;
  // Word layout
  localparam int unsigned CFG_WIDTH       = 14;
  localparam logic [13:0] CFG_ERASED      = 14'h3fff;
  localparam int unsigned CP_MSB          = 13;
  localparam int unsigned CP_LSB          = 4;
  localparam int unsigned POWERUP_DELAY_ENABLE_N_BIT       = 3;
  localparam int unsigned WATCHDOG_ENABLE_BIT_BIT        = 2;
  localparam int unsigned FOSC_MSB        = 1;
  localparam int unsigned FOSC_LSB        = 0;
  localparam logic [9:0]  CP_OFF_VALUE    = 10'h3ff;
  // Programming address space
  localparam logic [13:0] CFG_WORD_ADDR   = 14'h2007;
  localparam logic [13:0] TEST_SPACE_LO   = 14'h2000;
  localparam logic [13:0] TEST_SPACE_HI   = 14'h3fff;
  // Wishbone register offsets (byte addresses)
  localparam logic [7:0]  REG_CFG_WORD    = 8'h00;
  localparam logic [7:0]  REG_PROG_CTRL   = 8'h04;
  localparam logic [7:0]  REG_PROG_ADDR   = 8'h08;
  localparam logic [7:0]  REG_PROG_DATA   = 8'h0c;
  localparam logic [7:0]  REG_STATUS      = 8'h10;
  localparam logic [7:0]  REG_CTRL        = 8'h14;
  // Timing at 40 MHz
  localparam int unsigned CLK_HZ          = 40_000_000;
  localparam int unsigned POWERUP_DELAY_TIMER_MS         = 72;
  localparam int unsigned POWERUP_DELAY_TIMER_CYCLES     = (POWERUP_DELAY_TIMER_MS * (CLK_HZ / 1000));
  localparam int unsigned OST_OSC_CYCLES  = 1024;
  localparam int unsigned WDT_PERIOD_CYC  = 720_000;
  localparam int unsigned WDT_RC_DIV      = 4;
  // Oscillator modes
  typedef enum logic [1:0] {
    CWO_LP = 2'b00,
    CWO_XT = 2'b01,
    CWO_HS = 2'b10,
    CWO_RC = 2'b11
  } cwo_osc_e;
  // Decoded settings
  typedef struct packed {
    logic     code_protect;
    logic     powerup_delay_en;
    logic     watchdog_en;
    cwo_osc_e osc_mode;
  } cwo_cfg_s;
endpackage : cwo_pkg

//--- testbench/cwo_config_loader_chk.sv
// Port checker for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
module cwo_config_loader_chk #(
  parameter int unsigned POWERUP_DELAY_TIMER_CYC = 20,
  parameter int unsigned WDT_CYC  = 8
) (
  // Clock and reset
  input wire logic       clk,
  input wire logic       rst,
  // Bus
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  // Events
  input wire logic       ext_reset_req,
  input wire logic       irq_wake,
  // Settings
  input wire logic       core_reset,
  input wire logic       sleeping,
  input wire logic       wdt_timeout,
  input wire logic       code_protected,
  input wire logic       wdt_enabled,
  input wire logic [1:0] osc_mode_select
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Wake request while asleep, then awake soon
  sequence s_irq_asleep;
    sleeping && irq_wake;
  endsequence
  sequence s_awake;
    ##[1:3] !sleeping;
  endsequence
  AST_ACK_ONE: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
    else $error("ack not one pulse");
  AST_RST_STATE: assert property ($fell(rst) |-> core_reset && osc_mode_select == 2'h3 && !sleeping)
    else $error("reset state wrong");
  AST_WDT_OFF: assert property (!wdt_enabled |-> !wdt_timeout)
    else $error("watchdog fired while off");
  AST_HELD: assert property (!core_reset && !$past(core_reset) |->
    $stable(osc_mode_select) && $stable(wdt_enabled) && $stable(code_protected))
    else $error("settings changed in run");
  AST_EXT_RST: assert property (ext_reset_req |-> ##2 core_reset)
    else $error("external reset ignored");
  AST_IRQ_WAKE: assert property (s_irq_asleep |-> s_awake)
    else $error("no wake on interrupt");
  AST_WDT_RUN: assert property (wdt_timeout && !$past(sleeping) |-> ##[0:1] core_reset)
    else $error("watchdog gave no reset");
  AST_WDT_WAKE: assert property (wdt_timeout && $past(sleeping) |-> ##[0:2] (!sleeping && !core_reset))
    else $error("watchdog wake wrong");
endmodule : cwo_config_loader_chk
bind cwo_config_loader cwo_config_loader_chk #(.POWERUP_DELAY_TIMER_CYC(POWERUP_DELAY_TIMER_CYC), .WDT_CYC(WDT_CYC)) i_chk (
  .clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .ext_reset_req(ext_reset_req), .irq_wake(irq_wake), .core_reset(core_reset), .sleeping(sleeping),
  .wdt_timeout(wdt_timeout), .code_protected(code_protected), .wdt_enabled(wdt_enabled),
  .osc_mode_select(osc_mode_select));
`default_nettype wire

//--- testbench/cwo_config_loader_tb.sv
// Testbench for the configuration word loader
`timescale 1ns/1ps
`default_nettype none
module cwo_config_loader_tb;
  localparam int unsigned PW = 20;
  logic        clk = 1'b0, rst = 1'b1, cyc = 1'b0, we = 1'b0, ext = 1'b0;
  logic        irq = 1'b0, slp = 1'b0, clr = 1'b0, rc = 1'b1;
  logic [7:0]  adr = 8'h00;
  logic [31:0] wdat = 32'h0, rdat, dout;
  logic        ack, osc_startup_timer, rct, cres, slpg, wto, cpr, wen;
  logic [1:0]  osm;
  logic [1:0]  pm = 2'h3;
  int          fail_count = 0, tests_run = 0, n;
  logic [13:0] words [5] = '{14'h0000, 14'h3ffd, 14'h3ff2, 14'h3fff, 14'h3ff7};
  cwo_config_loader #(.POWERUP_DELAY_TIMER_CYC(PW), .WDT_CYC(8)) i_dut (
    .clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(4'hf), .wb_dat_i(wdat), .wb_dat_o(dout), .wb_ack_o(ack), .ext_reset_req(ext),
    .irq_wake(irq), .sleep_req(slp), .wdt_clear(clr), .osc_tick(osc_startup_timer), .wdt_rc_tick(rct),
    .core_reset(cres), .sleeping(slpg), .wdt_timeout(wto), .code_protected(cpr),
    .wdt_enabled(wen), .osc_mode_select(osm));
  cwo_osc_model i_osc (.clk(clk), .osc_run(1'b1), .rc_run(rc), .osc_tick(osc_startup_timer), .wdt_rc_tick(rct));
  // Clock
  initial forever #12.5 clk = ~clk;
  task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // One classic bus cycle, held until ack
  task automatic bus(logic w, logic [7:0] a, logic [31:0] d);
    @(posedge clk);
    cyc  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    rdat = dout;
    cyc <= 1'b0;
  endtask : bus
  // One-cycle pulse: 0 clear, 1 sleep, 2 wake interrupt
  task automatic pulse(int unsigned which);
    @(posedge clk);
    if (which == 0) clr <= 1'b1;
    else if (which == 1) slp <= 1'b1;
    else irq <= 1'b1;
    @(posedge clk);
    clr <= 1'b0;
    slp <= 1'b0;
    irq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : pulse
  // Power-on reset, counting cycles held in reset
  task automatic por();
    @(posedge clk);
    rst <= 1'b1;
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cres !== 1'b0);
  endtask : por
  task automatic end_of_test();
    $display("checks %0d failures %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : end_of_test
  // Watchdog on the whole run
  initial begin
    #1000000;
    fail_count++;
    end_of_test();
  end
  // Main sequence
  initial begin
    por();
    bus(1'b0, 8'h00, 32'h0);
    chk("cfg erased", rdat, 32'h3fff);
    bus(1'b1, 8'h08, 32'h2007);
    bus(1'b1, 8'h0c, 32'h0);
    bus(1'b0, 8'h0c, 32'h0);
    chk("data outside prog", rdat, 32'h0);
    bus(1'b0, 8'h20, 32'h0);
    chk("unmapped", rdat, 32'h0);
    foreach (words[i]) begin
      bus(1'b1, 8'h04, 32'h1);
      bus(1'b1, 8'h08, 32'h2007);
      bus(1'b1, 8'h0c, {18'h0, words[i]});
      bus(1'b1, 8'h04, 32'h0);
      chk("held", osm, pm);
      por();
      pm = words[i][1:0];
      bus(1'b0, 8'h00, 32'h0);
      chk("cfg", rdat, {18'h0, words[i]});
      chk("mode", osm, words[i][1:0]);
      chk("wdt en", wen, words[i][2]);
      chk("protect", cpr, words[i][13:4] != 10'h3ff);
      chk("powerup_delay_timer", n >= PW, !words[i][3] || words[i][1:0] != 2'h3);
      chk("ost", n >= 1024, words[i][1:0] != 2'h3);
    end
    rc <= 1'b0;
    pulse(0);
    ext <= 1'b1;
    @(posedge clk);
    ext <= 1'b0;
    @(posedge clk);
    @(negedge clk);
    chk("ext reset", cres, 1'b1);
    repeat (4) @(posedge clk);
    chk("no powerup_delay_timer rerun", cres, 1'b0);
    pulse(1);
    chk("asleep", slpg, 1'b1);
    pulse(2);
    chk("irq wake", slpg, 1'b0);
    pulse(1);
    rc <= 1'b1;
    n = 0;
    while (wto !== 1'b1 && n < 200) begin
      @(posedge clk);
      n++;
    end
    repeat (3) @(posedge clk);
    chk("wdt fired", n < 200, 1'b1);
    chk("wdt wake", {slpg, cres}, 2'h0);
    repeat (100) @(posedge clk);
    end_of_test();
  end
endmodule : cwo_config_loader_tb
`default_nettype wire

//--- testbench/cwo_osc_model.sv
// Crystal source and watchdog RC source model
`timescale 1ns/1ps
`default_nettype none
module cwo_osc_model (
  // Clock and run enables
  input  wire logic clk,
  input  wire logic osc_run,
  input  wire logic rc_run,
  // Oscillator pulses
  output logic      osc_tick,
  output logic      wdt_rc_tick
);
  logic [1:0] div = 2'h0;
  // Divider standing in for crystal and RC
  always_ff @(posedge clk) begin
    div         <= div + 2'h1;
    osc_tick    <= osc_run & div[0];
    wdt_rc_tick <= rc_run & (div == 2'h3);
  end
endmodule : cwo_osc_model
`default_nettype wire
